// >>> rtl/adc_conversion_sequencer.sv
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_consts.svh"

//Contract
//- regular group runs up to 16 slots, length from 4-bit field
//- injected group runs up to 4 slots, length from 2-bit field
//- any slot may name any channel, repeats allowed
//- writing a sequence register mid-conversion aborts and restarts the group
//- channel 16 selects temperature sensor, 17 the internal reference
//- without repeat, one conversion (or one scan) then stop
//- regular end stores result, sets regular done, may interrupt
//- injected end stores result, sets injected done, may interrupt
//- with repeat, a new conversion follows each one at once; the code idles after the injected group unless auto injection is on or regResume or pendReg is set
//- result and done flag appear 14 converter ticks after start
//- alert flag when value below lower or above upper threshold
//- threshold check uses raw value before alignment
//- guard enables and single-channel select choose guarded channels
//- scan walks the group, wraps to first slot when repeating
//- with transfer request on, each regular end requests dma
//- injected trigger aborts regular, runs injected group, resumes regular slot
//- regular trigger waits for injected group to finish
//- auto injection runs injected group after regular group
//- group switch inserts one tick, two ticks at prescaler two
//- first on powers up, second on starts, off powers down
//- triggers act on rising edge only
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              regularTrigger,
  input  wire logic              injectedTrigger,
  input  wire logic [`RES_W-1:0] sampleValue,
  output logic      [`SLOT_W-1:0] muxChannel,
  output logic                   tempSensorSelect,
  output logic                   referenceSelect,
  output logic                   powerUp,
  output logic                   converting,
  output logic                   dmaRequest,
  input  wire logic              dmaAck,
  output logic                   irq
);

  localparam int StabCycles = `STAB_CYCLES;

  ctrl1_t                  ctrlOne;
  ctrl2_t                  ctrlTwo;
  ctrl2_t                  wrTwo;
  status_t                 clearBits;
  logic [6*`SLOT_W-1:0]    regSeqA;
  logic [6*`SLOT_W-1:0]    regSeqB;
  rseq_tail_t              regSeqC;
  jseq_t                   injSeq;
  logic [`RES_W-1:0]       upperThreshold;
  logic [`RES_W-1:0]       lowerThreshold;
  logic [15:0]             regularResult;
  logic [15:0]             injectedResult;
  logic                    regularDone;
  logic                    injectedDone;
  logic                    thresholdAlert;
  logic                    busAck;
  logic                    wrStrobe;
  logic                    cr2Write;
  logic                    seqWrite;
  logic                    startReg;
  logic                    stable;
  logic [15:0]             stabCount;
  state_t                  state;
  logic                    injGroup;
  logic                    regResume;
  logic                    pendReg;
  logic                    pendInj;
  logic [3:0]              regIdx;
  logic [1:0]              injIdx;
  logic [1:0]              gapCount;
  logic [1:0]              gapLoad;
  logic [3:0]              tickCount;
  logic [2:0]              divCount;
  logic                    convTick;
  logic                    convDone;
  logic                    regTrigLast;
  logic                    injTrigLast;
  logic                    regTrigEdge;
  logic                    injTrigEdge;
  logic [16*`SLOT_W-1:0]   regSlots;
  logic [`SLOT_W-1:0]      slotChannel;
  logic                    regLast;
  logic                    injLast;
  conv_event_t             convEvent;
  logic                    guardHit;

  // avalon slave: one wait cycle on every access
  assign waitrequest = (read | write) & ~busAck;
  assign wrStrobe    = write & busAck;
  assign cr2Write    = wrStrobe && address == `OFS_CR2;
  assign wrTwo       = ctrl2_t'(writedata[$bits(ctrl2_t)-1:0]);
  assign clearBits   = (wrStrobe && address == `OFS_STATUS) ? status_t'(writedata[$bits(status_t)-1:0])
                                                             : status_t'(5'h00);
  assign seqWrite    = wrStrobe && (address == `OFS_RSEQ_A || address == `OFS_RSEQ_B ||
                                    address == `OFS_RSEQ_C || address == `OFS_JSEQ);

  always_ff @(posedge clock) begin
    if (rst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (read | write) & ~busAck;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !busAck) begin
      case (address)
        `OFS_STATUS: readdata <= {27'h000_0000, stable, converting, thresholdAlert, injectedDone, regularDone};
        `OFS_CR1:    readdata <= {19'h0_0000, ctrlOne};
        `OFS_CR2:    readdata <= {25'h000_0000, ctrlTwo};
        `OFS_RSEQ_A: readdata <= {2'h0, regSeqA};
        `OFS_RSEQ_B: readdata <= {2'h0, regSeqB};
        `OFS_RSEQ_C: readdata <= {8'h00, regSeqC};
        `OFS_JSEQ:   readdata <= {10'h000, injSeq};
        `OFS_UPPER:  readdata <= {20'h0_0000, upperThreshold};
        `OFS_LOWER:  readdata <= {20'h0_0000, lowerThreshold};
        `OFS_RDATA:  readdata <= {16'h0000, regularResult};
        `OFS_JDATA:  readdata <= {16'h0000, injectedResult};
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlOne        <= ctrl1_t'(`CR1_RESET);
      ctrlTwo        <= ctrl2_t'(`CR2_RESET);
      regSeqA        <= 30'h0000_0000;
      regSeqB        <= 30'h0000_0000;
      regSeqC        <= rseq_tail_t'(24'h00_0000);
      injSeq         <= jseq_t'(22'h00_0000);
      upperThreshold <= `UPPER_RESET;
      lowerThreshold <= `LOWER_RESET;
    end else if (wrStrobe) begin
      case (address)
        `OFS_CR1:    ctrlOne        <= ctrl1_t'(writedata[$bits(ctrl1_t)-1:0]);
        `OFS_CR2:    ctrlTwo        <= wrTwo;
        `OFS_RSEQ_A: regSeqA        <= writedata[6*`SLOT_W-1:0];
        `OFS_RSEQ_B: regSeqB        <= writedata[6*`SLOT_W-1:0];
        `OFS_RSEQ_C: regSeqC        <= rseq_tail_t'(writedata[$bits(rseq_tail_t)-1:0]);
        `OFS_JSEQ:   injSeq         <= jseq_t'(writedata[$bits(jseq_t)-1:0]);
        `OFS_UPPER:  upperThreshold <= writedata[`RES_W-1:0];
        `OFS_LOWER:  lowerThreshold <= writedata[`RES_W-1:0];
        default:     ctrlOne        <= ctrlOne;
      endcase
    end
  end

  // power-up and stabilisation
  always_ff @(posedge clock) begin
    if (rst || !ctrlTwo.converterOn) begin
      stabCount <= 16'h0000;
      stable    <= 1'b0;
    end else if (!stable) begin
      stabCount <= stabCount + 16'h0001;
      stable    <= stabCount == 16'(StabCycles - 1);
    end
  end

  assign powerUp  = ctrlTwo.converterOn;
  // a second on-write only starts once the analog side has settled
  assign startReg = cr2Write && wrTwo.converterOn && ctrlTwo.converterOn && stable;

  // trigger edges
  always_ff @(posedge clock) begin
    if (rst) begin
      regTrigLast <= 1'b0;
      injTrigLast <= 1'b0;
    end else begin
      regTrigLast <= regularTrigger;
      injTrigLast <= injectedTrigger;
    end
  end

  assign regTrigEdge = regularTrigger & ~regTrigLast & ctrlTwo.regularTriggerEnable & stable;
  assign injTrigEdge = injectedTrigger & ~injTrigLast & ctrlTwo.injectedTriggerEnable & stable;

  // converter clock enable: prescaler code n divides by 2n+2
  always_ff @(posedge clock) begin
    if (rst || convTick) begin
      divCount <= 3'h0;
    end else begin
      divCount <= divCount + 3'h1;
    end
  end

  assign convTick = divCount == {ctrlTwo.prescalerSetting, 1'b1};

  assign regSlots    = {regSeqC.slots, regSeqB, regSeqA};
  assign slotChannel = injGroup ? injSeq.slots[`SLOT_W*injIdx +: `SLOT_W]
                                : regSlots[`SLOT_W*regIdx +: `SLOT_W];
  assign regLast     = !ctrlOne.scanMode || regIdx == regSeqC.length;
  assign injLast     = !(ctrlOne.scanMode || ctrlOne.autoInjection) || injIdx == injSeq.length;
  assign convDone    = state == CONVERT && convTick && tickCount == 4'(`CONV_TICKS - 1);
  assign gapLoad     = (ctrlTwo.prescalerSetting == `PRESC_DIV2) ? 2'(`GAP_TICKS_DIV2 - 1)
                                                                 : 2'(`GAP_TICKS - 1);

  // sequencer
  always_ff @(posedge clock) begin
    if (rst || !ctrlTwo.converterOn) begin
      state     <= IDLE;
      injGroup  <= 1'b0;
      regResume <= 1'b0;
      pendReg   <= 1'b0;
      pendInj   <= 1'b0;
      regIdx    <= 4'h0;
      injIdx    <= 2'h0;
      tickCount <= 4'h0;
      gapCount  <= 2'h0;
    end else begin
      if (startReg || regTrigEdge) begin
        pendReg <= 1'b1;
      end
      if (injTrigEdge) begin
        pendInj <= 1'b1;
      end
      if (convTick && state == CONVERT) begin
        tickCount <= tickCount + 4'h1;
      end
      case (state)
        IDLE: begin
          tickCount <= 4'h0;
          if (pendInj) begin
            pendInj  <= 1'b0;
            injIdx   <= 2'h0;
            injGroup <= 1'b1;
            state    <= CONVERT;
          end else if (pendReg) begin
            pendReg  <= 1'b0;
            injGroup <= 1'b0;
            state    <= CONVERT;
          end
        end
        GAP: begin
          tickCount <= 4'h0;
          if (convTick) begin
            if (gapCount == 2'h0) begin
              state <= CONVERT;
            end else begin
              gapCount <= gapCount - 2'h1;
            end
          end
        end
        CONVERT: begin
          if (seqWrite) begin
            tickCount <= 4'h0;
            regIdx    <= 4'h0;
            injIdx    <= 2'h0;
          end else if (!injGroup && (injTrigEdge || pendInj)) begin
            // regIdx is kept so the aborted slot is redone afterwards
            pendInj   <= 1'b0;
            regResume <= 1'b1;
            injGroup  <= 1'b1;
            injIdx    <= 2'h0;
            gapCount  <= gapLoad;
            state     <= GAP;
          end else if (convDone) begin
            tickCount <= 4'h0;
            if (injGroup) begin
              if (!injLast) begin
                injIdx <= injIdx + 2'h1;
              end else begin
                injIdx <= 2'h0;
                if (regResume || pendReg || (ctrlOne.autoInjection && ctrlTwo.repeatConversions)) begin
                  regResume <= 1'b0;
                  pendReg   <= 1'b0;
                  injGroup  <= 1'b0;
                  gapCount  <= gapLoad;
                  state     <= GAP;
                end else begin
                  state <= IDLE;
                end
              end
            end else begin
              if (!regLast) begin
                regIdx <= regIdx + 4'h1;
              end else begin
                regIdx <= 4'h0;
                if (ctrlOne.autoInjection) begin
                  injGroup <= 1'b1;
                  gapCount <= gapLoad;
                  state    <= GAP;
                end else if (!ctrlTwo.repeatConversions) begin
                  state <= IDLE;
                end
              end
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  assign converting = state != IDLE;

  always_ff @(posedge clock) begin
    if (rst) begin
      muxChannel       <= 5'h00;
      tempSensorSelect <= 1'b0;
      referenceSelect  <= 1'b0;
    end else begin
      muxChannel       <= slotChannel;
      tempSensorSelect <= slotChannel == `CH_TEMP;
      referenceSelect  <= slotChannel == `CH_VREF;
    end
  end

  // results, right aligned with zero upper bits
  always_ff @(posedge clock) begin
    if (rst) begin
      regularResult  <= 16'h0000;
      injectedResult <= 16'h0000;
    end else if (convDone) begin
      if (injGroup) begin
        injectedResult <= {4'h0, sampleValue};
      end else begin
        regularResult <= {4'h0, sampleValue};
      end
    end
  end

  assign convEvent = '{valid: convDone, injected: injGroup, channel: muxChannel, value: sampleValue};

  threshold_guard u_guard (
    .clock      (clock),
    .rst        (rst),
    .convEvent  (convEvent),
    .ctrl       (ctrlOne),
    .upperBound (upperThreshold),
    .lowerBound (lowerThreshold),
    .guardHit   (guardHit)
  );

  // sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (rst) begin
      regularDone    <= 1'b0;
      injectedDone   <= 1'b0;
      thresholdAlert <= 1'b0;
      dmaRequest     <= 1'b0;
    end else begin
      regularDone    <= (regularDone & ~clearBits.regularDone) | (convDone & ~injGroup);
      injectedDone   <= (injectedDone & ~clearBits.injectedDone) | (convDone & injGroup);
      thresholdAlert <= (thresholdAlert & ~clearBits.thresholdAlert) | guardHit;
      dmaRequest     <= (dmaRequest & ~dmaAck) |
                        (convDone & ~injGroup & ctrlTwo.transferRequestEnable);
    end
  end

  assign irq = (regularDone & ctrlOne.regularDoneIrqEnable) |
               (injectedDone & ctrlOne.injectedDoneIrqEnable) |
               (thresholdAlert & ctrlOne.thresholdIrqEnable);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_regEnd;
    convDone && !injGroup;
  endsequence

  sequence s_injEnd;
    convDone && injGroup;
  endsequence

  property p_regResult;
    s_regEnd |=> regularDone && regularResult == {4'h0, $past(sampleValue)};
  endproperty
  a_regResult: assert property (p_regResult) else $error("regular result or flag missing");

  property p_injResult;
    s_injEnd |=> injectedDone && injectedResult == {4'h0, $past(sampleValue)} && !$rose(regularDone);
  endproperty
  a_injResult: assert property (p_injResult) else $error("injected result or flag missing");

  property p_convTicks;
    convDone |-> convTick && tickCount == 4'(`CONV_TICKS - 1) && $past(state) == CONVERT;
  endproperty
  a_convTicks: assert property (p_convTicks) else $error("conversion length wrong");

  property p_alert;
    guardHit |=> thresholdAlert;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not raised");

  property p_sticky;
    thresholdAlert && !clearBits.thresholdAlert |=> thresholdAlert;
  endproperty
  a_sticky: assert property (p_sticky) else $error("alert dropped without clear");

  property p_dma;
    (s_regEnd and ctrlTwo.transferRequestEnable) |=> dmaRequest;
  endproperty
  a_dma: assert property (p_dma) else $error("no transfer request");

  property p_injAbort;
    state == CONVERT && !injGroup && injTrigEdge && !seqWrite |=>
      state == GAP && injGroup && regResume && regIdx == $past(regIdx);
  endproperty
  a_injAbort: assert property (p_injAbort) else $error("injected trigger did not preempt");

  property p_noPreempt;
    state == CONVERT && injGroup && regTrigEdge && !convDone |=> injGroup && pendReg;
  endproperty
  a_noPreempt: assert property (p_noPreempt) else $error("regular trigger preempted injected");

  property p_off;
    !ctrlTwo.converterOn |=> !converting && !stable;
  endproperty
  a_off: assert property (p_off) else $error("converter still active when off");

  property p_edge;
    regularTrigger && $past(regularTrigger) |-> !regTrigEdge;
  endproperty
  a_edge: assert property (p_edge) else $error("trigger level acted as edge");

endmodule // adc_conversion_sequencer

`default_nettype wire

// >>> rtl/adc_seq_consts.svh
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// register byte offsets on the avalon slave
`define OFS_STATUS      6'h00
`define OFS_CR1         6'h04
`define OFS_CR2         6'h08
`define OFS_RSEQ_A      6'h0c
`define OFS_RSEQ_B      6'h10
`define OFS_RSEQ_C      6'h14
`define OFS_JSEQ        6'h18
`define OFS_UPPER       6'h1c
`define OFS_LOWER       6'h20
`define OFS_RDATA       6'h24
`define OFS_JDATA       6'h28

// widths
`define SLOT_W          5
`define RES_W           12

// reset values
`define CR1_RESET       13'h0000
`define CR2_RESET       7'h00
`define UPPER_RESET     12'hfff
`define LOWER_RESET     12'h000

// channels wired to internal sources
`define CH_TEMP         5'h10
`define CH_VREF         5'h11

// timing, in converter clock ticks unless noted
`define CONV_TICKS      14
`define PRESC_DIV2      2'h0
`define GAP_TICKS       1
`define GAP_TICKS_DIV2  2
`define STAB_NS         1000
`define CLK_MHZ         50
`define STAB_CYCLES     ((`STAB_NS * `CLK_MHZ + 999) / 1000)

`endif

// >>> rtl/adc_seq_pkg.sv
`default_nettype none
`include "adc_seq_consts.svh"

package adc_seq_pkg;

  typedef enum logic [1:0] {IDLE, GAP, CONVERT} state_t;

  typedef struct packed {
    logic              regularGuardEnable;
    logic              injectedGuardEnable;
    logic              autoInjection;
    logic              singleChannelGuard;
    logic              scanMode;
    logic              injectedDoneIrqEnable;
    logic              thresholdIrqEnable;
    logic              regularDoneIrqEnable;
    logic [`SLOT_W-1:0] guardedChannelSelect;
  } ctrl1_t;

  typedef struct packed {
    logic [1:0] prescalerSetting;
    logic       regularTriggerEnable;
    logic       injectedTriggerEnable;
    logic       transferRequestEnable;
    logic       repeatConversions;
    logic       converterOn;
  } ctrl2_t;

  typedef struct packed {
    logic stable;
    logic busy;
    logic thresholdAlert;
    logic injectedDone;
    logic regularDone;
  } status_t;

  typedef struct packed {
    logic [3:0]            length;
    logic [4*`SLOT_W-1:0]  slots;
  } rseq_tail_t;

  typedef struct packed {
    logic [1:0]            length;
    logic [4*`SLOT_W-1:0]  slots;
  } jseq_t;

  typedef struct packed {
    logic               valid;
    logic               injected;
    logic [`SLOT_W-1:0] channel;
    logic [`RES_W-1:0]  value;
  } conv_event_t;

endpackage

`default_nettype wire

// >>> rtl/threshold_guard.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_consts.svh"

module threshold_guard
  import adc_seq_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire conv_event_t       convEvent,
  input  wire ctrl1_t            ctrl,
  input  wire logic [`RES_W-1:0] upperBound,
  input  wire logic [`RES_W-1:0] lowerBound,
  output logic                   guardHit
);

  logic covered;
  logic outside;

  always_comb begin
    covered = (convEvent.injected ? ctrl.injectedGuardEnable : ctrl.regularGuardEnable) &&
              (!ctrl.singleChannelGuard || convEvent.channel == ctrl.guardedChannelSelect);
    // raw value, alignment never reaches here
    outside = (convEvent.value < lowerBound) || (convEvent.value > upperBound);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      guardHit <= 1'b0;
    end else begin
      guardHit <= convEvent.valid && covered && outside;
    end
  end

endmodule // threshold_guard

`default_nettype wire

// >>> tb/analog_dma_model.sv
`timescale 1ns/10ps
`default_nettype none
module analog_dma_model
  import adc_seq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        converting,
  input  wire logic [4:0]  muxChannel,
  input  wire logic [6:0]  base,
  input  wire logic        dmaRequest,
  output logic      [11:0] sampleValue,
  output logic             dmaAck,
  output int               ackCount
);
  logic [1:0] delay;
  // outside a conversion the input shows junk, never the last level
  assign sampleValue = converting ? {muxChannel, base} : ~{muxChannel, base};
  initial begin
    dmaAck = 1'b0;
    delay = 2'h0;
    ackCount = 0;
  end
  // slow engine: acks four cycles after a request
  always @(posedge clock) begin
    dmaAck <= 1'b0;
    if (dmaRequest && !dmaAck) begin
      delay <= delay + 2'h1;
      if (delay == 2'h3) begin
        dmaAck <= 1'b1;
        ackCount <= ackCount + 1;
        delay <= 2'h0;
      end
    end
  end
endmodule // analog_dma_model
`default_nettype wire

// >>> tb/adc_conversion_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_conversion_sequencer_test
  import adc_seq_pkg::*;
;
  logic        clock, rst, read, write, regularTrigger, injectedTrigger, dmaAck;
  logic [5:0]  address;
  logic [31:0] writedata, readdata, seed, rd;
  logic        waitrequest, tempSensorSelect, referenceSelect, powerUp, converting, dmaRequest, irq;
  logic [11:0] sampleValue;
  logic [4:0]  muxChannel, ch;
  logic [6:0]  base;
  logic        tempSeen, refSeen;
  int          fails, comparisons, ackCount, n;

  adc_conversion_sequencer dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .regularTrigger(regularTrigger),
    .injectedTrigger(injectedTrigger), .sampleValue(sampleValue), .muxChannel(muxChannel),
    .tempSensorSelect(tempSensorSelect), .referenceSelect(referenceSelect), .powerUp(powerUp),
    .converting(converting), .dmaRequest(dmaRequest), .dmaAck(dmaAck), .irq(irq));
  analog_dma_model far (.clock(clock), .converting(converting), .muxChannel(muxChannel), .base(base),
    .dmaRequest(dmaRequest), .sampleValue(sampleValue), .dmaAck(dmaAck), .ackCount(ackCount));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (tempSensorSelect === 1'b1) tempSeen <= 1'b1;
    if (referenceSelect === 1'b1) refSeen <= 1'b1;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      fails++;
      close_out();
    end
    // read data stand in the cycle that ends with waitrequest low
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_status(input int b);
    n = 0;
    do begin
      acc(1'b0, `OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    if (n >= 200) begin
      fails++;
      close_out();
    end
  endtask

  initial begin
    {rst, read, write, regularTrigger, injectedTrigger} = 5'h10;
    address = 6'h00;
    writedata = 32'h0000_0000;
    fails = 0;
    comparisons = 0;
    seed = 32'h0000_3c0c;
    base = 7'h00;
    {tempSeen, refSeen} = 2'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    acc(1'b0, `OFS_UPPER, 32'h0);
    chk(rd, 32'h0000_0fff);
    acc(1'b0, `OFS_CR1, 32'h0);
    chk(rd, 32'h0000_0000);
    acc(1'b0, 6'h2c, 32'h0);
    chk(rd, 32'h0000_0000);
    // single regular conversion, flags, irq, dma, alert
    ch = 5'(xs() % 16);
    base <= 7'(xs()) | 7'h01;
    acc(1'b1, `OFS_RSEQ_A, {27'h0, ch});
    acc(1'b1, `OFS_UPPER, 32'h0000_0000);
    acc(1'b1, `OFS_CR1, 32'h0000_1060);
    acc(1'b1, `OFS_CR2, 32'h0000_0001);
    // the write lands at the edge the task returns on
    @(negedge clock);
    chk({31'h0, powerUp}, 32'h1);
    wait_status(4);
    acc(1'b1, `OFS_CR2, 32'h0000_0005);
    wait_status(0);
    acc(1'b0, `OFS_RDATA, 32'h0);
    chk(rd, {20'h0, ch, base});
    repeat (3) @(posedge clock);
    acc(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_0007, 32'h0000_0005);
    chk({31'h0, converting}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    chk(32'(ackCount), 32'h1);
    acc(1'b1, `OFS_STATUS, 32'h0000_0007);
    acc(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_0007, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    // regular scan of three slots with both internal channels
    ch = 5'(xs() % 16);
    acc(1'b1, `OFS_UPPER, 32'h0000_0fff);
    acc(1'b1, `OFS_RSEQ_A, {17'h0, ch, 5'h11, 5'h10});
    acc(1'b1, `OFS_RSEQ_C, 32'h0020_0000);
    acc(1'b1, `OFS_CR1, 32'h0000_1100);
    acc(1'b1, `OFS_CR2, 32'h0000_0005);
    n = 0;
    while (ackCount < 4 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    chk(32'(ackCount), 32'h4);
    repeat (8) @(posedge clock);
    chk({30'h0, tempSeen, refSeen}, 32'h3);
    acc(1'b0, `OFS_RDATA, 32'h0);
    chk(rd, {20'h0, ch, base});
    acc(1'b0, `OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_0004, 32'h0);
    // triggered injection, started on the trigger's rising edge
    ch = 5'(xs() % 16);
    acc(1'b1, `OFS_JSEQ, {27'h0, ch});
    acc(1'b1, `OFS_CR1, 32'h0000_0180);
    acc(1'b1, `OFS_CR2, 32'h0000_0009);
    injectedTrigger <= 1'b1;
    wait_status(1);
    injectedTrigger <= 1'b0;
    acc(1'b0, `OFS_JDATA, 32'h0);
    chk(rd, {20'h0, ch, base});
    chk({31'h0, irq}, 32'h1);
    // auto injection with repeat: regular group, then injected group, round after round
    acc(1'b1, `OFS_CR2, 32'h0000_0000);
    acc(1'b1, `OFS_CR1, 32'h0000_0580);
    acc(1'b1, `OFS_CR2, 32'h0000_0003);
    wait_status(4);
    acc(1'b1, `OFS_CR2, 32'h0000_0003);
    acc(1'b1, `OFS_STATUS, 32'h0000_0007);
    wait_status(1);
    acc(1'b0, `OFS_JDATA, 32'h0);
    chk(rd, {20'h0, ch, base});
    acc(1'b1, `OFS_STATUS, 32'h0000_0007);
    wait_status(1);
    chk({31'h0, converting}, 32'h1);
    acc(1'b1, `OFS_CR2, 32'h0000_0000);
    // off lands at one edge, the sequencer clears at the next
    repeat (2) @(negedge clock);
    chk({30'h0, powerUp, converting}, 32'h0);
    close_out();
  end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
